//--- ams_defines.svh
// Purpose: constants of the address mapping selector
// Assumes: 8-bit register ports, 20-bit processor addresses
// Notes:   definitions only
`ifndef AMS_DEFINES_SVH
`define AMS_DEFINES_SVH

// ---------------------------------------------
// Register offsets
// ---------------------------------------------
`define AMS_IO_MAP_INDEX  16'h006C
`define AMS_IO_MAP_LOW    16'h006E
`define AMS_IO_MAP_HIGH   16'h006F
`define AMS_CFG_PIN_TOP   8'h14
`define AMS_CFG_PIN_MID   8'h15
`define AMS_CFG_PIN_LOW   8'h16

// ---------------------------------------------
// Address space landmarks (16 KB window numbers, 64 KB and 32 KB segment numbers)
// ---------------------------------------------
`define AMS_WIN_DIRECT_END 6'h28
`define AMS_WIN_EMS_FIRST  6'h28
`define AMS_WIN_EMS_LAST   6'h3B
`define AMS_SEG_BIOS       4'hF
`define AMS_SEG_DISP_WIDE  4'hA
`define AMS_SEG_DISP_NARW  5'h17

// ---------------------------------------------
// Field positions
// ---------------------------------------------
`define AMS_HI_PAGE_MSB    2
`define AMS_HI_TYPE_LSB    4
`define AMS_HI_TYPE_MSB    5
`define AMS_HI_ENABLE      7
`define AMS_LOW_IO_HOLD    0
`define AMS_LOW_DRAM_HOLD  1
`define AMS_LOW_A19_LSB    4
`define AMS_PAGE_W         11
`define AMS_OFS_W          14

// ---------------------------------------------
// Reset values
// ---------------------------------------------
`define AMS_RST_BYTE       8'h00
`define AMS_RST_ADDR       24'h000000
`define AMS_RST_PAIR       16'h0000
`define AMS_RST_WIN        6'h00

`endif

//--- ams_pkg.sv
// Purpose: shared types of the address mapping selector
// Assumes: nothing
// Notes:   constants live in ams_defines.svh
package ams_pkg;
   typedef enum logic [1:0] {
      AMS_TGT_RAM,
      AMS_TGT_BOOT_ROM,
      AMS_TGT_SECOND_ROM,
      AMS_TGT_NONE
   } ams_target_t;

   typedef enum logic [2:0] {
      AMS_ORG_256KX16,
      AMS_ORG_512KX8,
      AMS_ORG_1M,
      AMS_ORG_2MX8,
      AMS_ORG_4MX4
   } ams_dram_org_t;
endpackage

//--- ams_top.sv
// Purpose: address source selection, cycle claim and paged mapping
// Assumes: one cycle start pulse per bus cycle, inputs synchronous
// Notes:   data steering and strobes live elsewhere
`include "ams_defines.svh"

module ams_top #(
   parameter int NUM_PAIRS = 16
) (
   input  wire logic         core_clk,
   input  wire logic         sys_rst,
   input  wire logic         cycle_start,
   input  wire logic         cycle_is_io,
   input  wire logic         internal_target,
   input  wire logic [19:0]  cpu_raw_address,
   input  wire logic [19:0]  internal_latched_address,
   input  wire logic         card_claim,
   input  wire logic         display_window_select,
   input  wire logic         bios_in_rom,
   input  wire logic         ram_is_dram,
   input  wire logic [2:0]   dram_org,
   input  wire logic [7:0]   last_bank_top,
   input  wire logic         dram_col_phase,
   input  wire logic         io_wr,
   input  wire logic         io_rd,
   input  wire logic [15:0]  io_addr,
   input  wire logic [7:0]   io_wdata,
   input  wire logic         cfg_wr,
   input  wire logic         cfg_rd,
   input  wire logic [7:0]   cfg_index,
   input  wire logic [7:0]   cfg_wdata,
   output logic [23:0]       addr_pins_q,
   output logic              mcu_claim_q,
   output logic              card_cycle_q,
   output logic              exp_cycle_q,
   output logic [1:0]        target_q,
   output logic              cpu_clk_timed_q,
   output logic              rom_a24_q,
   output logic [7:0]        rdata_q
);
   // Pair select and window compare are sized for sixteen pairs only
   if (NUM_PAIRS != 16) begin : g_pairs_chk
      $error("ams_top supports exactly 16 mapping pairs");
   end

   // ---------------------------------------------
   // Register file
   // ---------------------------------------------
   logic [7:0]  map_window_index_q;
   logic [15:0] pair_q [NUM_PAIRS];
   logic [5:0]  pair_win_q [NUM_PAIRS];
   logic [7:0]  high_pin_enable_top_q;
   logic [7:0]  high_pin_enable_mid_q;
   logic [7:0]  low_pin_hold_config_q;
   logic [3:0]  sel;

   assign sel = map_window_index_q[3:0];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         map_window_index_q <= `AMS_RST_BYTE;
      end else if (io_wr && io_addr == `AMS_IO_MAP_INDEX) begin
         map_window_index_q <= io_wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_PAIRS; i++) begin
            pair_q[i]     <= `AMS_RST_PAIR;
            pair_win_q[i] <= `AMS_RST_WIN;
         end
      end else if (io_wr && io_addr == `AMS_IO_MAP_LOW) begin
         pair_q[sel][7:0] <= io_wdata;
         pair_win_q[sel]  <= map_window_index_q[5:0];
      end else if (io_wr && io_addr == `AMS_IO_MAP_HIGH) begin
         pair_q[sel][15:8] <= io_wdata;
         pair_win_q[sel]   <= map_window_index_q[5:0];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         high_pin_enable_top_q <= `AMS_RST_BYTE;
         high_pin_enable_mid_q <= `AMS_RST_BYTE;
         low_pin_hold_config_q <= `AMS_RST_BYTE;
      end else if (cfg_wr) begin
         if (cfg_index == `AMS_CFG_PIN_TOP) begin
            high_pin_enable_top_q <= cfg_wdata;
         end
         if (cfg_index == `AMS_CFG_PIN_MID) begin
            high_pin_enable_mid_q <= cfg_wdata;
         end
         if (cfg_index == `AMS_CFG_PIN_LOW) begin
            low_pin_hold_config_q <= cfg_wdata;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_q <= `AMS_RST_BYTE;
      end else if (io_rd) begin
         unique case (io_addr)
            `AMS_IO_MAP_INDEX: rdata_q <= map_window_index_q;
            `AMS_IO_MAP_LOW:   rdata_q <= pair_q[sel][7:0];
            `AMS_IO_MAP_HIGH:  rdata_q <= pair_q[sel][15:8];
            default:           rdata_q <= `AMS_RST_BYTE;
         endcase
      end else if (cfg_rd) begin
         unique case (cfg_index)
            `AMS_CFG_PIN_TOP: rdata_q <= high_pin_enable_top_q;
            `AMS_CFG_PIN_MID: rdata_q <= high_pin_enable_mid_q;
            `AMS_CFG_PIN_LOW: rdata_q <= low_pin_hold_config_q;
            default:          rdata_q <= `AMS_RST_BYTE;
         endcase
      end
   end

   // ---------------------------------------------
   // Memory controller decode
   // ---------------------------------------------
   logic [5:0]               win;
   logic                     ems_hit;
   logic [`AMS_PAGE_W-1:0]   ems_page;
   logic [1:0]               ems_type;
   logic                     low_hit;
   logic                     disp_hit;
   logic                     bios_hit;
   logic                     mcu_hit;
   logic [24:0]              phys;
   ams_pkg::ams_target_t     tgt;

   assign win = cpu_raw_address[19:`AMS_OFS_W];

   always_comb begin
      ems_hit  = 1'b0;
      ems_page = '0;
      ems_type = 2'h0;
      for (int i = 0; i < NUM_PAIRS; i++) begin
         if (!ems_hit && pair_q[i][8 + `AMS_HI_ENABLE] &&
             pair_win_q[i] == win &&
             win >= `AMS_WIN_EMS_FIRST && win <= `AMS_WIN_EMS_LAST) begin
            ems_hit  = 1'b1;
            ems_page = pair_q[i][8 + `AMS_HI_PAGE_MSB:0];
            ems_type = pair_q[i][8 + `AMS_HI_TYPE_MSB:8 + `AMS_HI_TYPE_LSB];
         end
      end
   end

   assign low_hit = win < `AMS_WIN_DIRECT_END;

   assign disp_hit = display_window_select ?
      (cpu_raw_address[19:16] == `AMS_SEG_DISP_WIDE) :
      (cpu_raw_address[19:15] == `AMS_SEG_DISP_NARW);

   assign bios_hit = bios_in_rom &&
      cpu_raw_address[19:16] == `AMS_SEG_BIOS;

   assign mcu_hit = !cycle_is_io &&
      (low_hit || disp_hit || bios_hit || ems_hit);

   always_comb begin
      phys = {5'h00, cpu_raw_address};
      tgt  = ams_pkg::AMS_TGT_NONE;
      if (low_hit) begin
         tgt = ams_pkg::AMS_TGT_RAM;
      end else if (disp_hit) begin
         tgt = ams_pkg::AMS_TGT_RAM;
         if (display_window_select) begin
            phys = {1'b0, last_bank_top, cpu_raw_address[15:0]};
         end else begin
            phys = {1'b0, last_bank_top, 1'b1, cpu_raw_address[14:0]};
         end
      end else if (bios_hit) begin
         tgt  = ams_pkg::AMS_TGT_BOOT_ROM;
         phys = {9'h000, cpu_raw_address[15:0]};
      end else if (ems_hit) begin
         tgt  = ams_pkg::ams_target_t'(ems_type);
         phys = {ems_page, cpu_raw_address[`AMS_OFS_W-1:0]};
         if (tgt == ams_pkg::AMS_TGT_RAM) begin
            phys[24] = 1'b0;
         end
      end
   end

   // ---------------------------------------------
   // Pin enables per memory type
   // ---------------------------------------------
   logic [4:0] pin_en;
   logic [2:0] en23;
   logic [2:0] en22;
   logic [2:0] en21;
   logic [2:0] en20;
   logic [2:0] en19;

   assign en23 = high_pin_enable_top_q[6:4];
   assign en22 = high_pin_enable_top_q[2:0];
   assign en21 = high_pin_enable_mid_q[6:4];
   assign en20 = high_pin_enable_mid_q[2:0];
   assign en19 = low_pin_hold_config_q[`AMS_LOW_A19_LSB+2:`AMS_LOW_A19_LSB];

   always_comb begin
      pin_en = 5'h00;
      if (tgt != ams_pkg::AMS_TGT_NONE) begin
         pin_en = {en23[tgt], en22[tgt], en21[tgt], en20[tgt], en19[tgt]};
      end
   end

   // ---------------------------------------------
   // Cycle routing and address pins
   // ---------------------------------------------
   logic [24:0] phys_q;
   logic        dram_q;
   logic        dram_hold;

   assign dram_hold = low_pin_hold_config_q[`AMS_LOW_DRAM_HOLD];

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mcu_claim_q     <= 1'b0;
         card_cycle_q    <= 1'b0;
         exp_cycle_q     <= 1'b0;
         target_q        <= ams_pkg::AMS_TGT_NONE;
         cpu_clk_timed_q <= 1'b0;
         rom_a24_q       <= 1'b0;
         phys_q          <= '0;
         dram_q          <= 1'b0;
      end else if (cycle_start) begin
         mcu_claim_q     <= mcu_hit;
         card_cycle_q    <= !mcu_hit && card_claim;
         exp_cycle_q     <= !mcu_hit && !card_claim;
         target_q        <= mcu_hit ? tgt : ams_pkg::AMS_TGT_NONE;
         cpu_clk_timed_q <= mcu_hit && !internal_target;
         rom_a24_q       <= mcu_hit && phys[24];
         phys_q          <= phys;
         dram_q          <= mcu_hit && ram_is_dram &&
                            tgt == ams_pkg::AMS_TGT_RAM;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_pins_q <= `AMS_RST_ADDR;
      end else if (cycle_start) begin
         if (cycle_is_io) begin
            addr_pins_q[15:0]  <= internal_latched_address[15:0];
            addr_pins_q[23:20] <= 4'h0;
            if (!low_pin_hold_config_q[`AMS_LOW_IO_HOLD]) begin
               addr_pins_q[19:16] <= 4'h0;
            end
         end else if (!mcu_hit) begin
            addr_pins_q[19:0]  <= internal_latched_address;
            addr_pins_q[23:20] <= 4'h0;
         end else if (ram_is_dram && tgt == ams_pkg::AMS_TGT_RAM) begin
            addr_pins_q[8:0] <= phys[18:10];
            if (dram_org != ams_pkg::AMS_ORG_256KX16) begin
               addr_pins_q[9] <= phys[19];
            end
            if (dram_org == ams_pkg::AMS_ORG_2MX8 ||
                dram_org == ams_pkg::AMS_ORG_4MX4) begin
               addr_pins_q[10] <= phys[21];
            end
            for (int p = 0; p < 4; p++) begin
               if (pin_en[p+1]) begin
                  addr_pins_q[20+p] <= phys[20+p];
               end
            end
            if (!dram_hold) begin
               addr_pins_q[19:12] <= phys[19:12];
            end
         end else begin
            addr_pins_q[18:0] <= phys[18:0];
            for (int p = 0; p < 5; p++) begin
               if (pin_en[p] || bios_hit) begin
                  addr_pins_q[19+p] <= (bios_hit && p > 0) ? 1'b0 : phys[19+p];
               end
            end
         end
      end else if (dram_col_phase && dram_q) begin
         addr_pins_q[8:0] <= phys_q[9:1];
         if (dram_org == ams_pkg::AMS_ORG_1M ||
             dram_org == ams_pkg::AMS_ORG_2MX8 ||
             dram_org == ams_pkg::AMS_ORG_4MX4) begin
            addr_pins_q[9] <= phys_q[20];
         end
         if (dram_org == ams_pkg::AMS_ORG_4MX4) begin
            addr_pins_q[10] <= phys_q[22];
         end
      end
   end
endmodule

//--- ams_far_card.sv
// Purpose: card controller stand-in on the far side of ams_top
// Assumes: claim is a level decided within the cycle
// Notes:   one 16 KB card window, placed by the bench
module ams_far_card (
   input  wire logic        win_on,
   input  wire logic [5:0]  win_num,
   input  wire logic [19:0] internal_latched_address,
   output logic             card_claim
);
   timeunit 1ns;
   timeprecision 100ps;
   assign card_claim = win_on && (internal_latched_address[19:14] == win_num);
endmodule

//--- ams_assertions.sv
// Purpose: port checks for ams_top
// Assumes: cycle answers land one edge after cycle_start
// Notes:   bound to every ams_top
module ams_chk (
   input wire logic        core_clk,
   input wire logic        sys_rst,
   input wire logic        cycle_start,
   input wire logic        cycle_is_io,
   input wire logic        internal_target,
   input wire logic [19:0] cpu_raw_address,
   input wire logic [19:0] internal_latched_address,
   input wire logic        card_claim,
   input wire logic        bios_in_rom,
   input wire logic        ram_is_dram,
   input wire logic        dram_col_phase,
   input wire logic [23:0] addr_pins_q,
   input wire logic        mcu_claim_q,
   input wire logic        card_cycle_q,
   input wire logic        exp_cycle_q,
   input wire logic [1:0]  target_q,
   input wire logic        cpu_clk_timed_q
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);
   logic mem_go;
   logic low_go;
   assign mem_go = cycle_start && !cycle_is_io;
   assign low_go = mem_go && (cpu_raw_address < 20'hA0000);
   AST_CARD_ROUTE: assert property (mem_go && card_claim |=> mcu_claim_q ^ card_cycle_q)
      else $error("card claim lost or doubled");
   AST_IO_PLAIN: assert property (cycle_start && cycle_is_io |=> !mcu_claim_q)
      else $error("io cycle was mapped");
   AST_EXP_ADDR: assert property (mem_go ##1 exp_cycle_q
      |-> addr_pins_q[19:0] == $past(internal_latched_address))
      else $error("expansion address wrong");
   AST_DIRECT: assert property (low_go && !ram_is_dram |=> mcu_claim_q && target_q == 2'h0
      && addr_pins_q[18:0] == $past(cpu_raw_address[18:0]))
      else $error("low memory not direct");
   AST_BIOS: assert property (mem_go && bios_in_rom && cpu_raw_address[19:16] == 4'hF
      |=> target_q == 2'h1 && addr_pins_q[23:16] == 8'h00)
      else $error("boot code cycle wrong");
   AST_ROW: assert property (low_go && ram_is_dram
      |=> addr_pins_q[8:0] == $past(cpu_raw_address[18:10]))
      else $error("row address wrong");
   AST_COL: assert property (low_go && ram_is_dram ##2 dram_col_phase
      |=> addr_pins_q[8:0] == $past(cpu_raw_address[9:1], 3))
      else $error("column address wrong");
   AST_HOLD: assert property (!cycle_start && !dram_col_phase |=> $stable(addr_pins_q))
      else $error("pins moved between cycles");
   AST_CLK_SRC: assert property (cycle_start && !internal_target
      |=> cpu_clk_timed_q == mcu_claim_q)
      else $error("cycle clock source wrong");
   AST_INTERNAL: assert property (cycle_start && internal_target |=> !cpu_clk_timed_q)
      else $error("internal cycle on cpu timing");
   cover property (mem_go && card_claim);
   cover property (low_go && ram_is_dram ##2 dram_col_phase);
   cover property (cycle_start && cycle_is_io);
endmodule

bind ams_top ams_chk i_ams_chk (.*);

//--- tb_top.sv
// Purpose: directed regression of ams_top
// Assumes: 200 MHz core clock, synchronous reset
// Notes:   card claims come from ams_far_card
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic        core_clk, card_claim, mcu_claim_q, card_cycle_q, exp_cycle_q, cpu_clk_timed_q;
   logic        sys_rst = 1'h1, cycle_start = 1'h0, cycle_is_io = 1'h0, card_on = 1'h0;
   logic        internal_target = 1'h0, display_window_select = 1'h0, bios_in_rom = 1'h0;
   logic        ram_is_dram = 1'h0, dram_col_phase = 1'h0, io_wr = 1'h0, io_rd = 1'h0;
   logic        cfg_wr = 1'h0, cfg_rd = 1'h0;
   logic [19:0] cpu_raw_address = 20'h0, internal_latched_address = 20'h0;
   logic [15:0] io_addr = 16'h0;
   logic [7:0]  io_wdata = 8'h0, cfg_index = 8'h0, cfg_wdata = 8'h0, last_bank_top = 8'h0;
   logic [7:0]  rdata_q;
   logic        rom_a24_q;
   logic [2:0]  dram_org = 3'h0;
   logic [1:0]  target_q;
   logic [23:0] addr_pins_q;
   int          n_errors = 0;
   int          total_checks = 0;

   ams_top i_ams_top (.*);
   ams_far_card i_ams_far_card (.win_on(card_on), .win_num(6'h30), .*);

   initial begin
      core_clk = 1'h0;
      forever #2.5 core_clk = ~core_clk;
   end

   // Whole run needs about 100 cycles
   initial begin
      #20000;
      n_errors++;
      close_out();
   end

   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s: %h not %h", $time, what, got, exp);
      end
   endtask

   task automatic clm(input logic [3:0] e);
      chk({20'h0, mcu_claim_q, card_cycle_q, exp_cycle_q, cpu_clk_timed_q}, {20'h0, e}, "claim");
   endtask

   task automatic wr(input logic cfg, input logic [15:0] a, input logic [7:0] d);
      @(posedge core_clk);
      io_wr <= !cfg;
      cfg_wr <= cfg;
      io_addr <= a;
      cfg_index <= a[7:0];
      io_wdata <= d;
      cfg_wdata <= d;
      @(posedge core_clk);
      io_wr <= 1'h0;
      cfg_wr <= 1'h0;
   endtask

   task automatic rd(input logic cfg, input logic [15:0] a, input logic [7:0] e);
      @(posedge core_clk);
      io_rd <= !cfg;
      cfg_rd <= cfg;
      io_addr <= a;
      cfg_index <= a[7:0];
      @(posedge core_clk);
      io_rd <= 1'h0;
      cfg_rd <= 1'h0;
      #1;
      chk({16'h0, rdata_q}, {16'h0, e}, "read");
   endtask

   // Kind bits: internal target, card window on, io cycle
   task automatic cyc(input logic [2:0] k, input logic [19:0] raw, input logic [19:0] lat);
      @(posedge core_clk);
      cycle_start <= 1'h1;
      cycle_is_io <= k[0];
      card_on <= k[1];
      internal_target <= k[2];
      cpu_raw_address <= raw;
      internal_latched_address <= lat;
      @(posedge core_clk);
      cycle_start <= 1'h0;
      #1;
   endtask

   initial begin
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'h0;
      @(posedge core_clk);
      #1;
      chk({22'h0, target_q}, 24'h3, "reset target");
      cyc(3'h0, 20'h05000, 20'h05000);
      clm(4'h9);
      chk(addr_pins_q, 24'h005000, "direct");
      cyc(3'h2, 20'hC0040, 20'hC0040);
      clm(4'h4);
      wr(1'h0, 16'h006C, 8'h30);
      wr(1'h0, 16'h006E, 8'h05);
      wr(1'h0, 16'h006F, 8'h80);
      rd(1'h0, 16'h006E, 8'h05);
      rd(1'h0, 16'h0070, 8'h00);
      cyc(3'h2, 20'hC0123, 20'hC0123);
      clm(4'h9);
      chk(addr_pins_q, 24'h094123, "mapped");
      cyc(3'h0, 20'hD0040, 20'hD0040);
      clm(4'h2);
      chk(addr_pins_q & 24'h0FFFFF, 24'h0D0040, "expansion");
      cyc(3'h4, 20'hD0040, 20'hD0040);
      chk({23'h0, cpu_clk_timed_q}, 24'h0, "internal");
      $display("claim test done");
      for (int t = 0; t < 3; t++) begin
         wr(1'h0, 16'h006F, 8'h84 | 8'(t << 4));
         cyc(3'h0, 20'hC0010, 20'hC0010);
         chk({22'h0, target_q}, 24'(t), "type");
         chk(addr_pins_q & 24'h0FFFFF, 24'h094010, "typed page");
         chk({23'h0, rom_a24_q}, 24'(t != 0), "rom page");
         clm(4'h9);
      end
      cyc(3'h1, 20'hC0123, 20'h00456);
      chk({7'h0, mcu_claim_q, addr_pins_q[15:0]}, 24'h000456, "io");
      @(posedge core_clk);
      bios_in_rom <= 1'h1;
      cyc(3'h0, 20'hF1234, 20'hF1234);
      chk(addr_pins_q, 24'h001234, "boot code");
      $display("type test done");
      wr(1'h1, 16'h0014, 8'h11);
      wr(1'h1, 16'h0015, 8'h11);
      wr(1'h1, 16'h0016, 8'h11);
      rd(1'h1, 16'h0016, 8'h11);
      @(posedge core_clk);
      last_bank_top <= 8'h3C;
      display_window_select <= 1'h1;
      cyc(3'h0, 20'hA0100, 20'hA0100);
      chk(addr_pins_q, 24'h3C0100, "wide window");
      cyc(3'h1, 20'hD0000, 20'h00456);
      chk(addr_pins_q & 24'h0FFFFF, 24'h0C0456, "io hold");
      @(posedge core_clk);
      display_window_select <= 1'h0;
      cyc(3'h0, 20'hB8100, 20'hB8100);
      chk(addr_pins_q, 24'h3C8100, "narrow window");
      wr(1'h1, 16'h0014, 8'h00);
      wr(1'h1, 16'h0015, 8'h00);
      @(posedge core_clk);
      last_bank_top <= 8'h50;
      cyc(3'h0, 20'hB8100, 20'hB8100);
      chk(addr_pins_q, 24'h308100, "pins held");
      $display("pin test done");
      @(posedge core_clk);
      ram_is_dram <= 1'h1;
      for (int o = 0; o < 5; o++) begin
         @(posedge core_clk);
         dram_org <= 3'(o);
         cyc(3'h0, 20'h9A5A4, 20'h9A5A4);
         chk({14'h0, addr_pins_q[9] && o > 0, addr_pins_q[8:0]}, {14'h0, o > 0, 9'h069}, "row");
         @(posedge core_clk);
         dram_col_phase <= 1'h1;
         @(posedge core_clk);
         dram_col_phase <= 1'h0;
         #1;
         chk({14'h0, addr_pins_q[9:0]}, {14'h0, o == 1, 9'h0D2}, "column");
      end
      wr(1'h1, 16'h0016, 8'h13);
      cyc(3'h0, 20'h45678, 20'h45678);
      chk({7'h0, addr_pins_q[19:12], addr_pins_q[8:0]}, {7'h0, 8'h9A, 9'h115}, "dram hold");
      $display("dram test done");
      close_out();
   end
endmodule
